// ### hw/ucb_pkg.sv
// package: register map, field positions, reset values and carriers of the serial port block
package ucb_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
	localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;
	localparam logic [7:0] ADDR_DIVISOR = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_FLAG_SET = 8'h14;

	// ****************************************
	// serial_control_two fields
	// ****************************************
	localparam int C2_TX_EN = 7;
	localparam int C2_RX_EN = 6;
	localparam int C2_SPEED = 5;
	localparam int C2_ADDR_DET = 4;
	localparam int C2_WAKE = 3;
	localparam int C2_RX_IE = 2;
	localparam int C2_TX_IDLE_FLAG_IE = 1;
	localparam int C2_TEMPTY_IE = 0;

	// control one fields (own layout)
	localparam int C1_MASTER_EN = 7;
	localparam int C1_LEN_SEL = 6;
	localparam int C1_WAKE_IE = 1;
	localparam int C1_ADDR_IE = 0;

	// status fields
	localparam int ST_RX_AVAIL = 0;
	localparam int ST_OVERRUN = 1;
	localparam int ST_TX_IDLE = 2;
	localparam int ST_TX_EMPTY = 3;
	localparam int ST_ADDR_HIT = 4;
	localparam int ST_WAKE_REQ = 5;
	localparam int ST_RX_BIT8 = 6;
	localparam int ST_RX_BIT7 = 7;

	// ****************************************
	// reset values and baud prescales
	// ****************************************
	localparam logic [7:0] CTRL_TWO_RST = 8'h00;
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [7:0] DIVISOR_RST = 8'h00;
	localparam logic [5:0] PRESCALE_LOW = 6'h3f;
	localparam logic [5:0] PRESCALE_HIGH = 6'h0f;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// received word from the shift engine
	typedef struct packed {
		logic valid;
		logic [8:0] word;
	} ucb_rx_word_s;

	// transmitter side status from the shift engine
	typedef struct packed {
		logic tx_idle;
		logic tx_empty;
	} ucb_tx_stat_s;

	typedef enum logic [1:0] {
		UCB_RX_OFF,
		UCB_RX_ON,
		UCB_RX_ABORT
	} ucb_rx_state_e;

endpackage : ucb_pkg

// ### hw/ucb_baud_gen.sv
// baud generator: prescaler plus reloading 8-bit timer
`timescale 1ns/1ps
`default_nettype none

module ucb_baud_gen #(
	parameter int DIV_W = 8
) (
	input wire logic i_ref_clk, // clock
	input wire logic i_reset, // sync reset
	input wire logic i_run, // master enable, clears counters when low
	input wire logic i_speed, // speed select
	input wire logic [DIV_W-1:0] i_divisor, // divisor N
	output logic o_tick // one pulse per bit time
);

	logic [5:0] pre_r;
	logic [DIV_W-1:0] tmr_r;
	logic pre_end;
	logic tick_r;

	// prescale 64 or 16 then divide by N+1
	assign pre_end = (pre_r == '0);

	always_ff @(posedge i_ref_clk) begin
		if (i_reset || !i_run) begin
			pre_r <= '0;
		end else if (pre_end) begin
			pre_r <= i_speed ? ucb_pkg::PRESCALE_HIGH : ucb_pkg::PRESCALE_LOW;
		end else begin
			pre_r <= pre_r - 6'h01;
		end
	end

	// free-running timer reloads at terminal count, so a new divisor lands there
	always_ff @(posedge i_ref_clk) begin
		if (i_reset || !i_run) begin
			tmr_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= 1'b0;
			if (pre_end) begin
				if (tmr_r == '0) begin
					tmr_r <= i_divisor;
					tick_r <= 1'b1;
				end else begin
					tmr_r <= tmr_r - 1'b1;
				end
			end
		end
	end

	assign o_tick = tick_r;

endmodule : ucb_baud_gen

`default_nettype wire

// ### hw/ucb_wake_det.sv
// rx pin synchroniser and wake-up falling edge detector
`timescale 1ns/1ps
`default_nettype none

module ucb_wake_det (
	input wire logic i_ref_clk, // clock
	input wire logic i_reset, // sync reset
	input wire logic i_rx_pin, // raw rx pin
	input wire logic i_arm, // wake bit set and port clock stopped
	output logic o_rx_sync, // synchronised rx level
	output logic o_fall // falling edge seen while armed
);

	logic s1_r;
	logic s2_r;
	logic s3_r;

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
		end else begin
			s1_r <= i_rx_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// edges only count while armed
	assign o_fall = i_arm && s3_r && !s2_r;
	assign o_rx_sync = s2_r;

endmodule : ucb_wake_det

`default_nettype wire

// ### hw/ucb_ctrl.sv
// serial port control, data and baud register block with AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none

module ucb_ctrl #(
	parameter int DIV_W = 8
) (
	input wire logic i_ref_clk, // 200 MHz clock
	input wire logic i_reset, // sync reset, active high
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic i_clk_stopped, // port clock fH is switched off
	input wire logic i_rx_pin, // rx pin level
	input wire ucb_pkg::ucb_rx_word_s i_rx_word, // word from shift engine
	input wire logic i_rx_busy, // shift engine mid-word
	input wire ucb_pkg::ucb_tx_stat_s i_tx_stat, // tx idle / empty levels
	input wire logic i_tx_load_ack, // shift engine took tx data
	output logic o_rx_run, // receiver enabled
	output logic o_rx_abort, // abort pulse to receiver
	output logic o_rx_pin_oe, // high while port owns rx pin
	output logic o_rx_sync, // synchronised rx level
	output logic o_tx_run, // transmitter enabled
	output logic o_nine_bit, // 9-bit format selected
	output logic [7:0] o_tx_data, // transmit byte
	output logic o_tx_load, // tx byte pending
	output logic o_baud_tick, // bit time pulse
	output logic o_irq // port interrupt request
);

	// ****************************************
	// registers
	// ****************************************
	logic [7:0] ctrl_one_r;
	logic [7:0] ctrl_two_r;
	logic [DIV_W-1:0] divisor_r;
	logic [7:0] rx_data_r;
	logic [7:0] tx_data_r;
	logic tx_load_r;
	logic rx_avail_r;
	logic overrun_r;
	logic addr_hit_r;
	logic wake_req_r;
	logic rx_bit8_r;
	ucb_pkg::ucb_rx_state_e rx_state_r;
	ucb_pkg::ucb_rx_state_e rx_state_nxt;

	logic master_en;
	logic rx_enabled;
	logic nine_bit;
	logic addr_bit;
	logic store_word;
	logic wake_fall;
	logic rd_data_hit;

	// AXI channel state
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic wr_fire;
	logic rd_fire;

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a == ucb_pkg::ADDR_CTRL_ONE) || (a == ucb_pkg::ADDR_CTRL_TWO) ||
			(a == ucb_pkg::ADDR_DATA) || (a == ucb_pkg::ADDR_DIVISOR) ||
			(a == ucb_pkg::ADDR_STATUS) || (a == ucb_pkg::ADDR_FLAG_SET);
	endfunction : known_addr

	// ****************************************
	// control decode
	// ****************************************
	assign master_en = ctrl_one_r[ucb_pkg::C1_MASTER_EN];
	assign nine_bit = ctrl_one_r[ucb_pkg::C1_LEN_SEL];
	assign rx_enabled = master_en && ctrl_two_r[ucb_pkg::C2_RX_EN];
	assign addr_bit = nine_bit ? i_rx_word.word[8] : i_rx_word.word[7];
	// with address detect on, only address words go into the buffer
	assign store_word = i_rx_word.valid && (rx_state_r == ucb_pkg::UCB_RX_ON) &&
		(!ctrl_two_r[ucb_pkg::C2_ADDR_DET] || addr_bit);

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_data_hit = rd_fire && (s_axi_araddr == ucb_pkg::ADDR_DATA);

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= ucb_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= known_addr(aw_addr_r) ? ucb_pkg::RESP_OKAY : ucb_pkg::RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= ucb_pkg::RESP_OKAY;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			rresp_r <= known_addr(s_axi_araddr) ? ucb_pkg::RESP_OKAY : ucb_pkg::RESP_SLVERR;
			if (s_axi_araddr == ucb_pkg::ADDR_CTRL_ONE) begin
				rdata_r <= {24'h000000, ctrl_one_r};
			end else if (s_axi_araddr == ucb_pkg::ADDR_CTRL_TWO) begin
				rdata_r <= {24'h000000, ctrl_two_r};
			end else if (s_axi_araddr == ucb_pkg::ADDR_DATA) begin
				rdata_r <= {24'h000000, rx_data_r};
			end else if (s_axi_araddr == ucb_pkg::ADDR_DIVISOR) begin
				rdata_r <= {{(32-DIV_W){1'b0}}, divisor_r};
			end else if (s_axi_araddr == ucb_pkg::ADDR_STATUS) begin
				rdata_r <= {24'h000000, rx_data_r[7], rx_bit8_r, wake_req_r, addr_hit_r,
					i_tx_stat.tx_empty, i_tx_stat.tx_idle, overrun_r, rx_avail_r};
			end else begin
				rdata_r <= 32'h0000_0000;
			end
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ****************************************
	// control registers
	// ****************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			ctrl_one_r <= ucb_pkg::CTRL_ONE_RST;
			ctrl_two_r <= ucb_pkg::CTRL_TWO_RST;
			divisor_r <= ucb_pkg::DIVISOR_RST[DIV_W-1:0];
		end else begin
			if (wr_fire && w_strb_r[0] && aw_addr_r == ucb_pkg::ADDR_CTRL_ONE) begin
				ctrl_one_r <= w_data_r[7:0];
			end
			if (wr_fire && w_strb_r[0] && aw_addr_r == ucb_pkg::ADDR_CTRL_TWO) begin
				ctrl_two_r <= w_data_r[7:0];
			end else if (!master_en) begin
				// disabling the port drops both enables, other bits survive
				ctrl_two_r[ucb_pkg::C2_TX_EN] <= 1'b0;
				ctrl_two_r[ucb_pkg::C2_RX_EN] <= 1'b0;
			end
			if (wr_fire && w_strb_r[0] && aw_addr_r == ucb_pkg::ADDR_DIVISOR) begin
				divisor_r <= w_data_r[DIV_W-1:0];
			end
		end
	end

	// ****************************************
	// receiver control
	// ****************************************
	always_comb begin
		rx_state_nxt = rx_state_r;
		case (rx_state_r)
			ucb_pkg::UCB_RX_OFF: begin
				if (rx_enabled) begin
					rx_state_nxt = ucb_pkg::UCB_RX_ON;
				end
			end
			ucb_pkg::UCB_RX_ON: begin
				if (!rx_enabled) begin
					rx_state_nxt = ucb_pkg::UCB_RX_ABORT;
				end
			end
			default: begin
				rx_state_nxt = ucb_pkg::UCB_RX_OFF;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rx_state_r <= ucb_pkg::UCB_RX_OFF;
		end else begin
			rx_state_r <= rx_state_nxt;
		end
	end

	// abort is pulsed on any drop of the enable, busy or not
	assign o_rx_abort = (rx_state_r == ucb_pkg::UCB_RX_ABORT) && 1'b1;
	assign o_rx_run = (rx_state_r == ucb_pkg::UCB_RX_ON);
	assign o_rx_pin_oe = (rx_state_r == ucb_pkg::UCB_RX_ON);

	// ****************************************
	// receive buffer and flags
	// ****************************************
	// a new word wins over a clear by the same data read
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			rx_avail_r <= 1'b0;
			overrun_r <= 1'b0;
			addr_hit_r <= 1'b0;
			rx_bit8_r <= 1'b0;
			rx_data_r <= 8'h00;
		end else if (!master_en || !rx_enabled) begin
			rx_avail_r <= 1'b0;
			overrun_r <= 1'b0;
			addr_hit_r <= 1'b0;
		end else if (store_word) begin
			rx_data_r <= i_rx_word.word[7:0];
			rx_bit8_r <= i_rx_word.word[8];
			rx_avail_r <= 1'b1;
			overrun_r <= overrun_r || (rx_avail_r && !rd_data_hit);
			addr_hit_r <= addr_hit_r || (ctrl_two_r[ucb_pkg::C2_ADDR_DET] && addr_bit);
		end else if (rd_data_hit) begin
			rx_avail_r <= 1'b0;
			overrun_r <= 1'b0;
			addr_hit_r <= 1'b0;
		end
	end

	// ****************************************
	// transmit holding register
	// ****************************************
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			tx_data_r <= 8'h00;
			tx_load_r <= 1'b0;
		end else if (!master_en || !ctrl_two_r[ucb_pkg::C2_TX_EN]) begin
			tx_load_r <= 1'b0;
		end else if (wr_fire && w_strb_r[0] && aw_addr_r == ucb_pkg::ADDR_DATA) begin
			tx_data_r <= w_data_r[7:0];
			tx_load_r <= 1'b1;
		end else if (i_tx_load_ack) begin
			tx_load_r <= 1'b0;
		end
	end

	assign o_tx_data = tx_data_r;
	assign o_tx_load = tx_load_r;
	assign o_tx_run = master_en && ctrl_two_r[ucb_pkg::C2_TX_EN];
	assign o_nine_bit = nine_bit;

	// ****************************************
	// wake-up
	// ****************************************
	ucb_wake_det u_wake (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_rx_pin(i_rx_pin),
		.i_arm(ctrl_two_r[ucb_pkg::C2_WAKE] && i_clk_stopped),
		.o_rx_sync(o_rx_sync),
		.o_fall(wake_fall)
	);

	// set wins over a write of 1 to the flag-clear location
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			wake_req_r <= 1'b0;
		end else if (wake_fall) begin
			wake_req_r <= 1'b1;
		end else if (wr_fire && w_strb_r[0] && aw_addr_r == ucb_pkg::ADDR_FLAG_SET &&
			w_data_r[ucb_pkg::ST_WAKE_REQ]) begin
			wake_req_r <= 1'b0;
		end
	end

	// ****************************************
	// baud generator
	// ****************************************
	ucb_baud_gen #(
		.DIV_W(DIV_W)
	) u_baud (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_run(master_en),
		.i_speed(ctrl_two_r[ucb_pkg::C2_SPEED]),
		.i_divisor(divisor_r),
		.o_tick(o_baud_tick)
	);

	// ****************************************
	// interrupt request
	// ****************************************
	logic irq_r;
	always_ff @(posedge i_ref_clk) begin
		if (i_reset) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (ctrl_two_r[ucb_pkg::C2_RX_IE] && (rx_avail_r || overrun_r)) ||
				(ctrl_two_r[ucb_pkg::C2_TX_IDLE_FLAG_IE] && master_en && i_tx_stat.tx_idle) ||
				(ctrl_two_r[ucb_pkg::C2_TEMPTY_IE] && master_en && i_tx_stat.tx_empty) ||
				(ctrl_one_r[ucb_pkg::C1_ADDR_IE] && addr_hit_r) ||
				(ctrl_one_r[ucb_pkg::C1_WAKE_IE] && wake_req_r);
		end
	end
	assign o_irq = irq_r;

endmodule : ucb_ctrl

`default_nettype wire

// ### verif/ucb_ctrl_chk.sv
// assertion checker for the serial port register block, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module ucb_ctrl_chk (
	input wire logic i_ref_clk, // clock
	input wire logic i_reset, // sync reset
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [1:0] s_axi_rresp, // read response
	input wire logic s_axi_rvalid, // read valid
	input wire logic s_axi_rready, // read ready
	input wire logic [1:0] s_axi_bresp, // write response
	input wire logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic i_rx_pin, // rx pin
	input wire logic o_rx_run, // receiver on
	input wire logic o_rx_abort, // abort pulse
	input wire logic o_rx_pin_oe, // rx pin owned
	input wire logic o_rx_sync, // synced rx
	input wire logic o_baud_tick, // bit pulse
	input wire logic o_irq // interrupt
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_reset);

	a_pin_owner: assert property (o_rx_pin_oe == o_rx_run)
		else $error("rx pin owned while receiver off");
	a_abort_off: assert property (o_rx_abort |-> !o_rx_run)
		else $error("abort while receiver runs");
	a_abort_pulse: assert property (o_rx_abort |=> !o_rx_abort)
		else $error("abort longer than one cycle");
	// the shortest bit time is 16 cycles, so a tick is never followed soon by another
	a_tick_gap: assert property (o_baud_tick |=> !o_baud_tick [*8])
		else $error("bit ticks too close");
	a_rx_sync: assert property (o_rx_sync == $past(i_rx_pin, 2))
		else $error("rx level not two cycles behind pin");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
		|=> s_axi_rresp == ucb_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
	// the bench holds ready up from the request, so check the release after the handshake
	a_read_done: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer not released after taken");
	a_write_done: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not released after taken");

	c_tick: cover property (o_baud_tick);
	c_abort: cover property (o_rx_abort);
	c_irq: cover property ($rose(o_irq));
endmodule : ucb_ctrl_chk

bind ucb_ctrl ucb_ctrl_chk u_chk (
	.i_ref_clk(i_ref_clk), .i_reset(i_reset), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.i_rx_pin(i_rx_pin), .o_rx_run(o_rx_run), .o_rx_abort(o_rx_abort),
	.o_rx_pin_oe(o_rx_pin_oe), .o_rx_sync(o_rx_sync), .o_baud_tick(o_baud_tick), .o_irq(o_irq)
);

`default_nettype wire

// ### verif/ucb_far_model.sv
// remote station and shift engine stand-in on the far side of the port
`timescale 1ns/1ps
`default_nettype none

module ucb_far_model (
	input wire logic i_ref_clk, // clock
	input wire logic i_tx_load, // tx byte pending
	output logic o_rx_pin, // rx line
	output ucb_pkg::ucb_rx_word_s o_rx_word, // received word
	output ucb_pkg::ucb_tx_stat_s o_tx_stat, // tx idle / empty
	output logic o_tx_load_ack // byte taken
);
	initial begin
		o_rx_pin = 1'b1;
		o_rx_word = '0;
		o_tx_stat = '0;
		o_tx_load_ack = 1'b0;
	end

	always @(posedge i_ref_clk) o_tx_load_ack <= i_tx_load && !o_tx_load_ack;

	// the word bus carries junk once valid drops, so stale data cannot pass
	task automatic send_word(input logic [8:0] w);
		@(posedge i_ref_clk);
		o_rx_word <= '{valid: 1'b1, word: w};
		@(posedge i_ref_clk);
		o_rx_word <= '{valid: 1'b0, word: ~w};
	endtask : send_word

	task automatic fall();
		@(posedge i_ref_clk);
		o_rx_pin <= 1'b0;
		repeat (6) @(posedge i_ref_clk);
		o_rx_pin <= 1'b1;
	endtask : fall

	task automatic set_tx(input logic idle, input logic empty);
		@(posedge i_ref_clk);
		o_tx_stat <= '{tx_idle: idle, tx_empty: empty};
	endtask : set_tx
endmodule : ucb_far_model

`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the serial port register block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	localparam logic [7:0] A_C1 = ucb_pkg::ADDR_CTRL_ONE;
	localparam logic [7:0] A_C2 = ucb_pkg::ADDR_CTRL_TWO;
	localparam logic [7:0] A_DAT = ucb_pkg::ADDR_DATA;
	localparam logic [7:0] A_DIV = ucb_pkg::ADDR_DIVISOR;
	localparam logic [7:0] A_ST = ucb_pkg::ADDR_STATUS;
	localparam logic [7:0] A_CLR = ucb_pkg::ADDR_FLAG_SET;
	logic clk, i_reset, awvalid, wvalid, bready, arvalid, rready, clk_stopped, rx_busy;
	logic awready, wready, bvalid, arready, rvalid, rx_pin, load_ack, rx_run, abort, pin_oe;
	logic tx_load, tick, irq, rx_sync, tx_run, nine_bit;
	logic [3:0] strb;
	logic [7:0] awaddr, araddr, tx_data;
	logic [31:0] wdata, rdata, rd_v;
	logic [1:0] bresp, rresp, rsp_v;
	ucb_pkg::ucb_rx_word_s rx_word;
	ucb_pkg::ucb_tx_stat_s tx_stat;
	int n_mismatch, tests_run, cyc, n_abort;

	ucb_ctrl dut (
		.i_ref_clk(clk), .i_reset(i_reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.i_clk_stopped(clk_stopped), .i_rx_pin(rx_pin), .i_rx_word(rx_word), .i_rx_busy(rx_busy),
		.i_tx_stat(tx_stat), .i_tx_load_ack(load_ack), .o_rx_run(rx_run), .o_rx_abort(abort),
		.o_rx_pin_oe(pin_oe), .o_rx_sync(rx_sync), .o_tx_run(tx_run), .o_nine_bit(nine_bit),
		.o_tx_data(tx_data),
		.o_tx_load(tx_load), .o_baud_tick(tick), .o_irq(irq)
	);

	ucb_far_model far (
		.i_ref_clk(clk), .i_tx_load(tx_load), .o_rx_pin(rx_pin), .o_rx_word(rx_word),
		.o_tx_stat(tx_stat), .o_tx_load_ack(load_ack)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(negedge clk) if (abort === 1'b1) n_abort++;

	// ****************************************
	// checking and bus tasks
	// ****************************************
	task automatic results();
		$display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic chk1(input logic s, input logic e);
		chk({31'h0, s}, {31'h0, e});
	endtask : chk1

	// ready is sampled at the falling edge so the decision never races the rising one
	task automatic axi(input logic wr, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] rd, output logic [1:0] rsp);
		logic fin_r, t_aw, t_w, t_ar, t_bus;
		fin_r = 1'b0;
		@(posedge clk);
		if (wr) begin
			awaddr <= a;
			wdata <= {24'h000000, d};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		while (!fin_r) begin
			@(negedge clk);
			t_aw = awvalid && awready;
			t_w = wvalid && wready;
			t_ar = arvalid && arready;
			t_bus = (bvalid && bready) || (rvalid && rready);
			rd = rdata;
			rsp = wr ? bresp : rresp;
			@(posedge clk);
			if (t_aw) awvalid <= 1'b0;
			if (t_w) wvalid <= 1'b0;
			if (t_ar) arvalid <= 1'b0;
			if (t_bus) begin
				bready <= 1'b0;
				rready <= 1'b0;
			end
			fin_r = t_bus;
		end
	endtask : axi

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		axi(1'b1, a, d, rd_v, rsp_v);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		axi(1'b0, a, 8'h00, rd_v, rsp_v);
		chk(rd_v & {24'h000000, m}, {24'h000000, e & m});
	endtask : rd_chk

	task automatic settle();
		repeat (4) @(negedge clk);
	endtask : settle

	task automatic period(input logic [7:0] d, input logic [7:0] c, input logic [31:0] e);
		logic [31:0] n;
		n = 0;
		wr(A_DIV, d);
		wr(A_C2, c);
		repeat (2) begin
			@(negedge clk);
			while (tick !== 1'b1) @(negedge clk);
		end
		do begin
			@(negedge clk);
			n++;
		end while (tick !== 1'b1);
		chk(n, e);
	endtask : period

	task automatic fin(input string s);
		$display("test %s finished", s);
	endtask : fin

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, clk_stopped, rx_busy} = '0;
		i_reset = 1'b1;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		strb = 4'h1;
		repeat (5) @(posedge clk);
		i_reset <= 1'b0;
		rd_chk(A_C2, 8'h00);
		rd_chk(A_DIV, 8'h00);
		axi(1'b0, 8'h40, 8'h00, rd_v, rsp_v);
		chk({30'h0, rsp_v}, {30'h0, ucb_pkg::RESP_SLVERR});
		wr(A_DIV, 8'ha5);
		strb <= 4'h0;
		wr(A_DIV, 8'h11);
		strb <= 4'h1;
		rd_chk(A_DIV, 8'ha5);
		wr(A_C1, 8'h80);
		wr(A_C2, 8'hac);
		rd_chk(A_C2, 8'hac);
		chk1(tx_run, 1'b1);
		wr(A_DAT, 8'h96);
		chk1(tx_load, 1'b1);
		settle();
		chk1(tx_load, 1'b0);
		chk({24'h000000, tx_data}, 32'h00000096);
		fin("registers");
		period(8'h02, 8'h00, 32'd192);
		period(8'h02, 8'h20, 32'd48);
		period(8'h00, 8'h20, 32'd16);
		fin("baud");
		wr(A_C2, 8'h44);
		settle();
		chk1(rx_run & pin_oe, 1'b1);
		far.send_word(9'h05a);
		settle();
		chk1(irq, 1'b1);
		rd_chk(A_ST, 8'h01);
		rd_chk(A_DAT, 8'h5a);
		settle();
		chk1(irq, 1'b0);
		far.send_word(9'h011);
		far.send_word(9'h022);
		rd_chk(A_ST, 8'h03, 8'h03);
		rd_chk(A_DAT, 8'h22);
		wr(A_C2, 8'h40);
		far.send_word(9'h033);
		settle();
		chk1(irq, 1'b0);
		rd_chk(A_DAT, 8'h33);
		fin("receive");
		wr(A_C1, 8'h81);
		wr(A_C2, 8'h50);
		far.send_word(9'h03c);
		settle();
		chk1(irq, 1'b0);
		rd_chk(A_ST, 8'h00, 8'h13);
		far.send_word(9'h0c3);
		settle();
		chk1(irq, 1'b1);
		rd_chk(A_ST, 8'h91);
		rd_chk(A_DAT, 8'hc3);
		wr(A_C1, 8'hc1);
		chk1(nine_bit, 1'b1);
		far.send_word(9'h085);
		settle();
		rd_chk(A_ST, 8'h00, 8'h13);
		far.send_word(9'h105);
		settle();
		rd_chk(A_ST, 8'h51);
		rd_chk(A_DAT, 8'h05);
		fin("address");
		wr(A_C1, 8'h80);
		wr(A_C2, 8'h44);
		far.send_word(9'h077);
		rx_busy <= 1'b1;
		n_abort = 0;
		wr(A_C2, 8'h04);
		settle();
		chk(n_abort, 1);
		chk1(rx_run | pin_oe, 1'b0);
		chk1(irq, 1'b0);
		rd_chk(A_ST, 8'h00, 8'h13);
		rx_busy <= 1'b0;
		far.send_word(9'h066);
		rd_chk(A_ST, 8'h00, 8'h01);
		fin("abort");
		wr(A_C2, 8'h02);
		far.set_tx(1'b1, 1'b0);
		settle();
		chk1(irq, 1'b1);
		rd_chk(A_ST, 8'h04, 8'h0c);
		far.set_tx(1'b0, 1'b1);
		settle();
		chk1(irq, 1'b0);
		wr(A_C2, 8'h01);
		settle();
		chk1(irq, 1'b1);
		far.set_tx(1'b1, 1'b0);
		settle();
		chk1(irq, 1'b0);
		far.set_tx(1'b0, 1'b0);
		fin("transmit flags");
		wr(A_C1, 8'h82);
		wr(A_C2, 8'h08);
		far.fall();
		chk1(rx_sync, 1'b0);
		settle();
		chk1(rx_sync, 1'b1);
		chk1(irq, 1'b0);
		rd_chk(A_ST, 8'h00, 8'h20);
		@(posedge clk) clk_stopped <= 1'b1;
		far.fall();
		settle();
		chk1(irq, 1'b1);
		rd_chk(A_ST, 8'h20, 8'h20);
		wr(A_CLR, 8'h20);
		wr(A_C2, 8'h00);
		far.fall();
		settle();
		chk1(irq, 1'b0);
		rd_chk(A_ST, 8'h00, 8'h20);
		@(posedge clk) clk_stopped <= 1'b0;
		fin("wake");
		wr(A_DIV, 8'h5c);
		wr(A_C2, 8'he4);
		far.send_word(9'h0aa);
		wr(A_C1, 8'h00);
		settle();
		chk1(irq, 1'b0);
		chk1(tx_run, 1'b0);
		rd_chk(A_ST, 8'h00, 8'h13);
		rd_chk(A_C2, 8'h24);
		rd_chk(A_DIV, 8'h5c);
		fin("disable");
		results();
	end
endmodule : tb_top

`default_nettype wire
